// ===== design/rgvb_defines.svh
// Functional notes
// RL1 - top bit 1 turns regulator off
// RL2 - read-only bit shows live supply level
// RL3 - polarity bit picks low or high trigger
// RL4 - irq only when enabled and level matches
// RL5 - irq level-sensitive, no pending flag kept
// RL6 - reset request when selected and level matches
// RL7 - mode bit 1 selects low-power suspend
// RL8 - low four bits read zero, write zero
// RL9 - writes never alter the status bit
`ifndef RGVB_DEFINES_SVH
`define RGVB_DEFINES_SVH
`define RGVB_CTRL_OFFSET 12'h000
`define RGVB_CFG_OFFSET 12'h004
`define RGVB_CTRL_RESET 8'h00
`define RGVB_CFG_RESET 2'h0
`define RGVB_BIT_OFF 7
`define RGVB_BIT_LEVEL 6
`define RGVB_BIT_POL 5
`define RGVB_BIT_LOWPWR 4
`define RGVB_BIT_IRQ_EN 0
`define RGVB_BIT_RST_EN 1
`define RGVB_RSVD_MASK 8'h0F
`endif

// ===== design/rgvb_match.sv
`timescale 1ns/1ps
// compares the supply level with the chosen polarity
module rgvb_match (
    input wire logic level,
    input wire logic polarity,
    output logic match
);
    // high polarity matches a high level, low matches low
    assign match = (level == polarity); // [RL3]
endmodule : rgvb_match

// ===== design/rgvb_pkg.sv
package rgvb_pkg;
    typedef logic [7:0] rgvb_ctrl_t;
    typedef logic [1:0] rgvb_cfg_t;
endpackage : rgvb_pkg

// ===== design/rgvb_top.sv
`timescale 1ns/1ps
`include "rgvb_defines.svh"
module rgvb_top
    import rgvb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bus_supply_in,
    output logic regulator_off,
    output logic regulator_low_power_sel,
    output logic bus_supply_irq,
    output logic bus_supply_reset_req
);
    rgvb_ctrl_t ctrl;
    rgvb_ctrl_t next_ctrl;
    rgvb_cfg_t cfg;
    rgvb_cfg_t next_cfg;
    logic wr_pend;
    logic next_wr_pend;
    logic [11:0] wr_addr;
    logic [11:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic match;
    logic bus_supply_level;
    logic irq_q;
    logic next_irq;
    logic rst_q;
    logic next_rst;

    // read view of control register, live level and zero low nibble
    function automatic logic [7:0] ctrl_view(input rgvb_ctrl_t c, input logic lvl);
        ctrl_view = {c[7], lvl, c[5:4], 4'h0}; // [RL2] [RL8]
    endfunction : ctrl_view

    assign bus_supply_level = bus_supply_in; // [RL2]

    rgvb_match u_match (
        .level(bus_supply_level),
        .polarity(ctrl[`RGVB_BIT_POL]),
        .match(match)
    );

    // bus answers at once, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // register file and ahb slave next values
    always_comb begin
        next_ctrl = ctrl;
        next_cfg = cfg;
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_hrdata = hrdata;
        if (wr_pend) begin
            if (wr_addr == `RGVB_CTRL_OFFSET) begin
                // status bit and reserved bits are not stored
                next_ctrl = hwdata[7:0] & 8'hB0; // [RL1] [RL7] [RL8] [RL9]
            end else if (wr_addr == `RGVB_CFG_OFFSET) begin
                next_cfg = hwdata[1:0];
            end
        end
        if (hsel && hready && htrans[1]) begin
            next_wr_pend = hwrite;
            next_wr_addr = {haddr[11:2], 2'b00};
            if (!hwrite) begin
                if ({haddr[11:2], 2'b00} == `RGVB_CTRL_OFFSET) begin
                    next_hrdata = {24'h000000, ctrl_view(ctrl, bus_supply_level)};
                end else if ({haddr[11:2], 2'b00} == `RGVB_CFG_OFFSET) begin
                    next_hrdata = {30'h0, cfg};
                end else begin
                    next_hrdata = 32'h00000000; // unmapped reads zero
                end
            end
        end
    end

    // event outputs follow the match one clock later, registered but with no pending flag
    always_comb begin
        next_irq = cfg[`RGVB_BIT_IRQ_EN] & match; // [RL4] [RL5]
        next_rst = cfg[`RGVB_BIT_RST_EN] & match; // [RL6]
    end

    // register state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `RGVB_CTRL_RESET;
            cfg <= `RGVB_CFG_RESET;
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata <= 32'h00000000;
            irq_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            cfg <= next_cfg;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            irq_q <= next_irq;
            rst_q <= next_rst;
        end
    end

    assign regulator_off = ctrl[`RGVB_BIT_OFF]; // [RL1]
    assign regulator_low_power_sel = ctrl[`RGVB_BIT_LOWPWR]; // [RL7]
    assign bus_supply_irq = irq_q;
    assign bus_supply_reset_req = rst_q;
endmodule : rgvb_top

// ===== testbench/rgvb_monitor.sv
`timescale 1ns/1ps
module rgvb_monitor(input wire logic hclk, hresetn, hsel, bus_supply_in, hreadyout, hresp,
    input wire logic regulator_off, regulator_low_power_sel, bus_supply_irq,
    input wire logic bus_supply_reset_req,
    input wire logic [31:0] hrdata);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // bus answer and read-back format
    a_ready_high: assert property (hreadyout) else $error("wait state");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_rsvd_zero: assert property (hrdata[3:0] == 4'h0) else $error("low bits");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper bits");
    // outputs move only after bus traffic or a supply change
    a_off_hold: assert property (!hsel [*3] |=> $stable(regulator_off)) else $error("off");
    a_mode_hold: assert property (!hsel [*3] |=> $stable(regulator_low_power_sel))
        else $error("mode");
    a_irq_hold: assert property ((!hsel && $stable(bus_supply_in)) [*3] |=>
        $stable(bus_supply_irq)) else $error("irq");
    a_rst_hold: assert property ((!hsel && $stable(bus_supply_in)) [*3] |=>
        $stable(bus_supply_reset_req)) else $error("reset");
endmodule : rgvb_monitor
bind rgvb_top rgvb_monitor u_rgvb_monitor(.*);

// ===== testbench/rgvb_supply_model.sv
`timescale 1ns/1ps
// host side: bus supply follows attach one cycle later
module rgvb_supply_model(input wire logic hclk, attach, output logic bus_supply_in);
    always_ff @(posedge hclk) bus_supply_in <= attach;
endmodule : rgvb_supply_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, attach = 0;
    logic [1:0] htrans = 0;
    logic [11:0] haddr = 0;
    logic [31:0] hwdata = 0, hrdata, r, d;
    logic hreadyout, hresp, bus_supply_in, regulator_off, regulator_low_power_sel;
    logic bus_supply_irq, bus_supply_reset_req;
    int fails = 0, checks_done = 0, cyc = 0;
    rgvb_top u_rgvb_top(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bus_supply_in, .regulator_off,
        .regulator_low_power_sel, .bus_supply_irq, .bus_supply_reset_req);
    rgvb_supply_model u_rgvb_supply_model(.hclk, .attach, .bus_supply_in);
    initial forever #2 hclk = ~hclk;
    // cut a hang short
    always @(posedge hclk) if (++cyc > 3000) begin
        fails++;
        summarize();
    end
    task summarize();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one single AHB transfer, address phase then data phase
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    initial begin
        void'($urandom(32'h929FC0C9));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(0, 12'h000, 0);
        chk(r, 0);
        repeat (4) begin
            d = $urandom;
            attach <= d[8];
            xfer(1, 12'h000, d & 32'hF0);
            repeat (3) @(posedge hclk);
            xfer(0, 12'h000, 0);
            chk(r, {d[7], d[8], d[5:4], 4'h0});
            chk({regulator_off, regulator_low_power_sel}, {d[7], d[4]});
        end
        $display("test control done");
        for (int c = 0; c < 16; c++) begin
            xfer(1, 12'h000, {c[0], 5'h0});
            xfer(1, 12'h004, c[3:2]);
            attach <= c[1];
            repeat (3) @(posedge hclk);
            chk(bus_supply_irq, c[2] & (c[1] == c[0]));
            chk(bus_supply_reset_req, c[3] & (c[1] == c[0]));
        end
        $display("test supply done");
        xfer(1, 12'h008, $urandom);
        xfer(0, 12'h008, 0);
        chk(r, 0);
        $display("test unmapped done");
        summarize();
    end
endmodule : tb
